/* inc/pfis_pkg.sv */
// Constants, register map and state types for the PWM fault input select block.
// Assumes a 32-bit classic Wishbone bus with byte addressing; only addr[3:0] is decoded.
package pfis_pkg;
    localparam logic [3:0]  ADDR_FAULT_LIMIT_CONTROL = 4'h0;
    localparam logic [3:0]  ADDR_PWM_IO_CONTROL      = 4'h4;
    localparam logic [3:0]  ADDR_UNLOCK              = 4'h8;
    localparam logic [3:0]  ADDR_STATUS              = 4'hc;

    localparam int          SRC_LSB                  = 3;
    localparam int          POL_BIT                  = 2;
    localparam int          MODE_LSB                 = 0;
    localparam logic [15:0] FAULT_LIMIT_CONTROL_RST  = 16'h00f8;
    localparam logic [15:0] CTRL_WRITE_MASK          = 16'h7fff;
    localparam logic [1:0]  PWM_IO_CONTROL_RST       = 2'h0;

    localparam int          STAT_LATCHED_BIT         = 0;
    localparam int          STAT_ACTIVE_BIT          = 1;
    localparam int          STAT_OPEN_BIT            = 2;
    localparam logic [15:0] UNLOCK_KEY_FIRST         = 16'habcd;
    localparam logic [15:0] UNLOCK_KEY_SECOND        = 16'h4321;

    localparam logic [4:0]  SRC_FAULT1               = 5'h00;
    localparam logic [4:0]  SRC_FAULT4               = 5'h03;
    localparam logic [4:0]  SRC_OPAMP1               = 5'h08;
    localparam logic [4:0]  SRC_OPAMP3               = 5'h0a;
    localparam logic [4:0]  SRC_CMP4                 = 5'h0b;
    localparam logic [4:0]  SRC_FAULT32              = 5'h1f;

    localparam logic [1:0]  MODE_LATCHED             = 2'h0;
    localparam logic [1:0]  MODE_CYCLE               = 2'h1;
    localparam logic [1:0]  MODE_RESERVED            = 2'h2;
    localparam logic [1:0]  MODE_DISABLED            = 2'h3;

    localparam int          NUM_SOURCES              = 9;

    typedef enum logic [2:0]
    {
        LOCK_CLOSED = 3'b001,
        LOCK_KEYED  = 3'b010,
        LOCK_OPEN   = 3'b100
    } pfis_lock_type;

    typedef struct packed
    {
        logic [NUM_SOURCES-1:0] syncFirst;
        logic [NUM_SOURCES-1:0] syncSecond;
        logic [15:0]            faultLimitControl;
        logic [1:0]             faultOverrideValues;
        pfis_lock_type          lockState;
        logic                   faultLatched;
        logic                   faultActive;
        logic                   pwmHighOutput;
        logic                   pwmLowOutput;
        logic                   ack;
        logic [31:0]            readData;
    } pfis_state_type;
endpackage

/* rtl/pfis_top.sv */
// PWM fault input select: source mux, polarity, override mode, Wishbone registers.
// Assumes fault and PWM inputs are synchronous to sys_clk and the lock strap moves only while the bus is idle.
`timescale 1ns/10ps
`default_nettype none
module pfis_top
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    input  wire logic [3:0]  faultPin,
    input  wire logic [2:0]  opampOut,
    input  wire logic        comparator4Out,
    input  wire logic        fault32In,
    input  wire logic        pwmRegisterLock,
    input  wire logic        pwmHighIn,
    input  wire logic        pwmLowIn,
    output var  logic        pwmHighOutput,
    output var  logic        pwmLowOutput
);
    pfis_pkg::pfis_state_type r;
    pfis_pkg::pfis_state_type next_r;

    // Reserved codes pick nothing, so they can never raise a fault
    // Polarity is applied per listed code, so an active-low setting cannot turn a reserved code into a fault
    function automatic logic selectSource(input logic [4:0] code, input logic [8:0] src, input logic pol);
        logic hit;
        hit = 1'b0;
        if (code <= pfis_pkg::SRC_FAULT4)
        begin
            hit = src[code[1:0]] ^ pol;
        end
        else if (code >= pfis_pkg::SRC_OPAMP1 && code <= pfis_pkg::SRC_OPAMP3)
        begin
            hit = src[4 + code[1:0]] ^ pol;
        end
        else if (code == pfis_pkg::SRC_CMP4)
        begin
            hit = src[7] ^ pol;
        end
        else if (code == pfis_pkg::SRC_FAULT32)
        begin
            hit = src[8] ^ pol;
        end
        return hit;
    endfunction

    logic [4:0]  srcSel;
    logic        polarity;
    logic [1:0]  mode;
    logic        asserted;
    logic        faultNow;
    logic        override;
    logic        access;
    logic        writeOk;
    logic [15:0] wdata;

    always_comb
    begin
        next_r   = r;
        srcSel   = r.faultLimitControl[pfis_pkg::SRC_LSB +: 5];
        polarity = r.faultLimitControl[pfis_pkg::POL_BIT];
        mode     = r.faultLimitControl[pfis_pkg::MODE_LSB +: 2];
        access   = wb_cyc_i && wb_stb_i && !r.ack;
        writeOk  = access && wb_we_i;
        wdata    = wb_dat_i[15:0];

        next_r.syncFirst  = {fault32In, comparator4Out, opampOut, faultPin};
        next_r.syncSecond = r.syncFirst;
        asserted = selectSource(srcSel, r.syncSecond, polarity);
        // Reserved mode behaves as disabled so a stray code cannot force the outputs
        faultNow = asserted && (mode == pfis_pkg::MODE_LATCHED || mode == pfis_pkg::MODE_CYCLE);
        next_r.faultActive = faultNow;

        // Clear only when the fault has gone; a new fault in the same cycle wins
        if (writeOk && wb_adr_i == pfis_pkg::ADDR_STATUS && wb_sel_i[0]
            && wdata[pfis_pkg::STAT_LATCHED_BIT] && !r.faultActive)
        begin
            next_r.faultLatched = 1'b0;
        end
        if (r.faultActive && mode == pfis_pkg::MODE_LATCHED)
        begin
            next_r.faultLatched = 1'b1;
        end

        override = r.faultLatched || (r.faultActive && mode == pfis_pkg::MODE_CYCLE);
        next_r.pwmHighOutput = override ? r.faultOverrideValues[0] : pwmHighIn;
        next_r.pwmLowOutput  = override ? r.faultOverrideValues[1] : pwmLowIn;

        next_r.ack      = access;
        next_r.readData = 32'h0000_0000;
        if (access && !wb_we_i)
        begin
            case (wb_adr_i)
                pfis_pkg::ADDR_FAULT_LIMIT_CONTROL:
                    next_r.readData[15:0] = r.faultLimitControl;
                pfis_pkg::ADDR_PWM_IO_CONTROL:
                    next_r.readData[1:0] = r.faultOverrideValues;
                pfis_pkg::ADDR_STATUS:
                    next_r.readData[2:0] = {r.lockState == pfis_pkg::LOCK_OPEN, r.faultActive,
                                            r.faultLatched};
                default:
                    next_r.readData = 32'h0000_0000;
            endcase
        end

        if (writeOk && wb_adr_i == pfis_pkg::ADDR_FAULT_LIMIT_CONTROL)
        begin
            if (wb_sel_i[0])
            begin
                next_r.faultLimitControl[7:0] = wdata[7:0];
            end
            if (wb_sel_i[1])
            begin
                next_r.faultLimitControl[15:8] = wdata[15:8] & pfis_pkg::CTRL_WRITE_MASK[15:8];
            end
        end

        // The key pair arms a single write to the I/O control register
        if (writeOk && wb_adr_i == pfis_pkg::ADDR_PWM_IO_CONTROL && wb_sel_i[0])
        begin
            if (!pwmRegisterLock || r.lockState == pfis_pkg::LOCK_OPEN)
            begin
                next_r.faultOverrideValues = wdata[1:0];
            end
            next_r.lockState = pfis_pkg::LOCK_CLOSED;
        end
        else if (writeOk && wb_adr_i == pfis_pkg::ADDR_UNLOCK && wb_sel_i[1:0] == 2'b11)
        begin
            case (r.lockState)
                pfis_pkg::LOCK_CLOSED:
                    next_r.lockState = (wdata == pfis_pkg::UNLOCK_KEY_FIRST)
                                       ? pfis_pkg::LOCK_KEYED : pfis_pkg::LOCK_CLOSED;
                pfis_pkg::LOCK_KEYED:
                    next_r.lockState = (wdata == pfis_pkg::UNLOCK_KEY_SECOND)
                                       ? pfis_pkg::LOCK_OPEN : pfis_pkg::LOCK_CLOSED;
                pfis_pkg::LOCK_OPEN:
                    next_r.lockState = pfis_pkg::LOCK_OPEN;
                default:
                    next_r.lockState = pfis_pkg::LOCK_CLOSED;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r                     <= '0;
            r.faultLimitControl   <= pfis_pkg::FAULT_LIMIT_CONTROL_RST;
            r.faultOverrideValues <= pfis_pkg::PWM_IO_CONTROL_RST;
            r.lockState           <= pfis_pkg::LOCK_CLOSED;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign wb_dat_o      = r.readData;
    assign wb_ack_o      = r.ack;
    assign pwmHighOutput = r.pwmHighOutput;
    assign pwmLowOutput  = r.pwmLowOutput;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    chk_source_fault_pins: assert property (
        (srcSel == pfis_pkg::SRC_FAULT1 && !polarity && !$changed(srcSel) && !$changed(polarity))
        |-> (asserted == $past(faultPin[0], 2)))
        else $error("Fault 1 not routed");
    chk_source_comparator4: assert property (
        (srcSel == pfis_pkg::SRC_CMP4 && !polarity) |-> (asserted == $past(comparator4Out, 2)))
        else $error("Comparator 4 not routed");
    chk_reset_source_code: assert property (
        $rose(rst_n) |-> (srcSel == pfis_pkg::SRC_FAULT32))
        else $error("Source select not at default after reset");
    chk_polarity_low_active: assert property (
        (srcSel == pfis_pkg::SRC_FAULT1 && polarity) |-> (asserted == !$past(faultPin[0], 2)))
        else $error("Active-low polarity wrong");
    chk_disabled_no_fault: assert property (
        (mode == pfis_pkg::MODE_DISABLED) |-> ##1 !r.faultActive)
        else $error("Disabled mode raised a fault");
    chk_cycle_override_follows: assert property (
        (r.faultActive && mode == pfis_pkg::MODE_CYCLE && !r.faultLatched)
        |=> (pwmHighOutput == $past(r.faultOverrideValues[0])))
        else $error("Cycle override not applied");
    chk_cycle_resume_normal: assert property (
        (!r.faultActive && !r.faultLatched) |=> (pwmLowOutput == $past(pwmLowIn)))
        else $error("Normal output not resumed");
    chk_latch_holds: assert property (
        (r.faultActive && mode == pfis_pkg::MODE_LATCHED)
        |=> r.faultLatched ##1 (r.faultLatched || !$past(r.faultActive)))
        else $error("Latched fault dropped early");
    chk_locked_write_blocked: assert property (
        (pwmRegisterLock && writeOk && wb_adr_i == pfis_pkg::ADDR_PWM_IO_CONTROL
         && r.lockState != pfis_pkg::LOCK_OPEN) |=> $stable(r.faultOverrideValues))
        else $error("Locked I/O control write accepted");
    chk_clear_needs_idle: assert property (
        ($fell(r.faultLatched)) |-> !$past(r.faultActive))
        else $error("Latch cleared while fault asserted");
    chk_ack_one_cycle: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("Ack held too long");
endmodule
`default_nettype wire

/* sim/pfis_fault_src.sv */
// Far-side model: the nine fault sources of one PWM generator.
// Assumes the bench changes srcSel, level and restLevel just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module pfis_fault_src
(
    input  wire logic [3:0] srcSel,
    input  wire logic       level,
    input  wire logic       restLevel,
    output var  logic [3:0] faultPin,
    output var  logic [2:0] opampOut,
    output var  logic       comparator4Out,
    output var  logic       fault32In
);
    logic [8:0] src;
    // Unselected sources sit at their idle level so a wrong select cannot pass by luck
    always_comb
    begin
        for (int i = 0; i < 9; i++)
        begin
            src[i] = (srcSel == 4'(i)) ? level : restLevel;
        end
    end
    assign faultPin       = src[3:0];
    assign opampOut       = src[6:4];
    assign comparator4Out = src[7];
    assign fault32In      = src[8];
endmodule
`default_nettype wire

/* sim/pwm_fault_input_select_tb.sv */
// Self-checking bench for the PWM fault input select block.
// Assumes a Wishbone slave that answers within 20 cycles and a lock strap that may move while the bus is idle.
`timescale 1ns/10ps
`default_nettype none
module pwm_fault_input_select_tb;
    logic        sys_clk;
    logic        rst_n;
    logic        cyc;
    logic        stb;
    logic        we;
    logic        hIn;
    logic        lIn;
    logic        lvl;
    logic        rest;
    logic        lockStrap;
    logic        pwmH;
    logic        pwmL;
    logic        ack;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [3:0]  srcSel;
    logic [3:0]  fPin;
    logic [31:0] datI;
    logic [31:0] datO;
    logic [31:0] q;
    logic [2:0]  opa;
    logic        cmp4;
    logic        f32;
    int          miscompares;
    int          check_count;
    // Only listed source codes are ever programmed
    logic [4:0]  codes [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h1f};
    localparam logic [1:0] OVR = 2'h1;
    localparam logic [1:0] NRM = 2'h2;

    pfis_fault_src pfis_fault_src_inst (.srcSel(srcSel), .level(lvl), .restLevel(rest), .faultPin(fPin),
        .opampOut(opa), .comparator4Out(cmp4), .fault32In(f32));
    pfis_top pfis_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .faultPin(fPin),
        .opampOut(opa), .comparator4Out(cmp4), .fault32In(f32), .pwmRegisterLock(lockStrap), .pwmHighIn(hIn),
        .pwmLowIn(lIn), .pwmHighOutput(pwmH), .pwmLowOutput(pwmL));

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic test_done();
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
            miscompares++;
        end
    endtask

    // Request stands from one rising edge to the rising edge that samples ack high; data taken at that edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        datI <= d;
        sel  <= 4'hf;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1)
        begin
            miscompares++;
            test_done();
        end
        else
        begin
            q = datO;
            cyc <= 1'b0;
            stb <= 1'b0;
            we  <= 1'b0;
        end
    endtask

    // Configuration moves only between scenarios, while the generator inputs stand still
    task automatic ctrl(input logic [4:0] s, input logic p, input logic [1:0] m);
        bus(1'b1, pfis_pkg::ADDR_FAULT_LIMIT_CONTROL, {24'h0, s, p, m});
    endtask

    // Four edges from source to pins, five in latched mode; sample mid-cycle after the fifth edge
    task automatic apply(input logic [3:0] s, input logic l, input logic r);
        @(posedge sys_clk);
        srcSel <= s;
        lvl    <= l;
        rest   <= r;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic test_registers();
        bus(1'b0, pfis_pkg::ADDR_FAULT_LIMIT_CONTROL, 32'h0);
        chk("control reset", q, 32'h000000f8);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped read", q, 32'h0);
    endtask

    task automatic test_lock();
        bus(1'b1, pfis_pkg::ADDR_PWM_IO_CONTROL, 32'h2);
        bus(1'b0, pfis_pkg::ADDR_PWM_IO_CONTROL, 32'h0);
        chk("locked io write", q, 32'h0);
        bus(1'b1, pfis_pkg::ADDR_UNLOCK, {16'h0, pfis_pkg::UNLOCK_KEY_FIRST});
        bus(1'b1, pfis_pkg::ADDR_UNLOCK, {16'h0, pfis_pkg::UNLOCK_KEY_SECOND});
        bus(1'b0, pfis_pkg::ADDR_STATUS, 32'h0);
        chk("unlock open", q & 32'h4, 32'h4);
        bus(1'b1, pfis_pkg::ADDR_PWM_IO_CONTROL, 32'h2);
        bus(1'b0, pfis_pkg::ADDR_PWM_IO_CONTROL, 32'h0);
        chk("unlocked io write", q, 32'h2);
        bus(1'b0, pfis_pkg::ADDR_STATUS, 32'h0);
        chk("unlock spent", q & 32'h4, 32'h0);
        // Strap moves only while the bus is idle
        lockStrap <= 1'b0;
        bus(1'b1, pfis_pkg::ADDR_PWM_IO_CONTROL, 32'h1);
        bus(1'b0, pfis_pkg::ADDR_PWM_IO_CONTROL, 32'h0);
        chk("strap off io write", q, 32'h1);
        bus(1'b1, pfis_pkg::ADDR_PWM_IO_CONTROL, 32'h2);
        lockStrap <= 1'b1;
    endtask

    task automatic test_sweep();
        for (int i = 0; i < 9; i++)
        begin
            ctrl(codes[i], 1'b0, pfis_pkg::MODE_CYCLE);
            apply(4'((i + 1) % 9), 1'b1, 1'b0);
            chk("other source", {30'h0, pwmH, pwmL}, {30'h0, NRM});
            apply(4'(i), 1'b1, 1'b0);
            chk("selected source", {30'h0, pwmH, pwmL}, {30'h0, OVR});
            apply(4'(i), 1'b0, 1'b0);
            chk("cycle release", {30'h0, pwmH, pwmL}, {30'h0, NRM});
        end
    endtask

    task automatic test_polarity();
        ctrl(5'h00, 1'b1, pfis_pkg::MODE_CYCLE);
        apply(4'h0, 1'b1, 1'b1);
        chk("low polarity idle", {30'h0, pwmH, pwmL}, {30'h0, NRM});
        apply(4'h0, 1'b0, 1'b1);
        chk("low polarity fault", {30'h0, pwmH, pwmL}, {30'h0, OVR});
    endtask

    task automatic test_modes();
        ctrl(5'h00, 1'b0, pfis_pkg::MODE_DISABLED);
        apply(4'h0, 1'b1, 1'b0);
        chk("mode disabled", {30'h0, pwmH, pwmL}, {30'h0, NRM});
        ctrl(5'h00, 1'b0, pfis_pkg::MODE_RESERVED);
        apply(4'h0, 1'b1, 1'b0);
        chk("mode reserved", {30'h0, pwmH, pwmL}, {30'h0, NRM});
        apply(4'h0, 1'b0, 1'b0);
    endtask

    task automatic test_latch();
        ctrl(5'h00, 1'b0, pfis_pkg::MODE_LATCHED);
        apply(4'h0, 1'b1, 1'b0);
        chk("latch set", {30'h0, pwmH, pwmL}, {30'h0, OVR});
        // Clear while the fault still stands must not take
        bus(1'b1, pfis_pkg::ADDR_STATUS, 32'h1);
        apply(4'h0, 1'b0, 1'b0);
        chk("latch hold", {30'h0, pwmH, pwmL}, {30'h0, OVR});
        bus(1'b0, pfis_pkg::ADDR_STATUS, 32'h0);
        chk("latch status", q & 32'h3, 32'h1);
        bus(1'b1, pfis_pkg::ADDR_STATUS, 32'h1);
        apply(4'h0, 1'b0, 1'b0);
        chk("latch cleared", {30'h0, pwmH, pwmL}, {30'h0, NRM});
    endtask

    initial
    begin
        miscompares = 0;
        check_count = 0;
        rst_n       = 1'b0;
        cyc         = 1'b0;
        stb         = 1'b0;
        we          = 1'b0;
        adr         = 4'h0;
        sel         = 4'h0;
        datI        = 32'h0;
        hIn         = 1'b1;
        lIn         = 1'b0;
        srcSel      = 4'h0;
        lvl         = 1'b0;
        rest        = 1'b0;
        lockStrap   = 1'b1;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        test_registers();
        test_lock();
        test_sweep();
        test_polarity();
        test_modes();
        test_latch();
        test_done();
    end
endmodule
`default_nettype wire
